// >>> hdl/tprc_core.v
/*
 * Touch pattern evaluation, base count limit flags and recalibration
 * configuration with sample averaging and update period timing.
 * Assumes a classic Wishbone master, and per-input delta counts, noise
 * flags and base limit flags, and one shared sample strobe, from the sensing front end,
 * all synchronous to clk_i.
 */
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`include "tprc_regs.vh"

module tprc_core #(
  parameter DW = 8,
  parameter NIN = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire cycle_done_i,
  input wire [NIN*DW-1:0] delta_i,
  input wire [NIN-1:0] noise_i,
  input wire [NIN-1:0] base_limit_i,
  input wire [NIN-1:0] neg_delta_i,
  input wire sample_strobe_i,
  input wire [DW-1:0] sample_i,
  output reg pattern_event_status_o,
  output reg touch_block_o,
  output reg alert_o,
  output reg base_limit_summary_o,
  output reg neg_recal_o,
  output reg base_update_o,
  output reg [DW-1:0] base_avg_o
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [7:0] mask_r;
  reg [7:0] bclim_r;
  reg [7:0] recal_r;
  reg [7:0] pcfg_r;
  reg [6:0] thr_r [0:NIN-1];
  reg [5:0] neg_cnt_r;
  reg [DW+8:0] acc_r;
  reg [8:0] samp_cnt_r;
  reg [12:0] per_cnt_r;
  reg cond_r;

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0] idx = wb_adr_i[9:2];
  // Writes land on the ack edge, the one at which the master takes the answer
  wire wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

  // Population count of a byte
  function [3:0] popcnt;
    input [7:0] v;
    integer k;
    begin
      popcnt = 4'd0;
      for (k = 0; k < 8; k = k + 1) begin
        popcnt = popcnt + {3'd0, v[k]};
      end
    end
  endfunction

  // Pattern threshold from touch threshold, eighths keep it exact
  function [DW-1:0] pthr;
    input [6:0] t;
    input [1:0] code;
    reg [DW+1:0] t3;
    begin
      // Two spare bits so three times a large threshold cannot wrap
      t3 = {{(DW-5){1'b0}}, t} + {{(DW-5){1'b0}}, t} + {{(DW-5){1'b0}}, t};
      case (code)
        2'b00: pthr = {{(DW-7){1'b0}}, t} >> 3;
        2'b01: pthr = {{(DW-7){1'b0}}, t} >> 2;
        2'b10: pthr = {1'b0, t3[DW+1:3]};
        default: pthr = {{(DW-7){1'b0}}, t};
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Qualifying inputs, bit n is input n+1
  // --------------------------------------------------------------------
  wire [NIN-1:0] qual;
  genvar g;
  generate
    for (g = 0; g < NIN; g = g + 1) begin : g_qual
      // Noise counts as qualifying; same threshold rule for all inputs
      assign qual[g] = noise_i[g] |
        (delta_i[g*DW +: DW] > pthr(thr_r[g], pcfg_r[`TPRC_PC_TH_HI:`TPRC_PC_TH_LO]));
    end
  endgenerate

  // Specific compares exact set; count compares population
  wire match_spec = (qual == mask_r);
  wire match_cnt = (popcnt(qual) >= popcnt(mask_r));
  wire match = pcfg_r[`TPRC_PC_CMP] ? match_spec : match_cnt;

  // --------------------------------------------------------------------
  // Wishbone slave, one wait state: ack one cycle after request
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h00000000;
      // Read data stands only in the ack cycle, zero otherwise
      if (req && !wb_we_i) begin
        if (idx == `TPRC_IDX_MASK)
          wb_dat_o[7:0] <= mask_r;
        else if (idx == `TPRC_IDX_BCLIM)
          wb_dat_o[7:0] <= bclim_r;
        else if (idx == `TPRC_IDX_RECAL)
          wb_dat_o[7:0] <= recal_r;
        else if (idx == `TPRC_IDX_PCFG)
          wb_dat_o[7:0] <= pcfg_r;
        else if (idx == `TPRC_IDX_STAT)
          wb_dat_o[7:0] <= {6'd0, base_limit_summary_o, pattern_event_status_o};
        else if (idx >= `TPRC_IDX_THR1 && idx <= `TPRC_IDX_THR8)
          wb_dat_o[7:0] <= {1'b0, thr_r[idx[2:0]]};
      end
    end
  end

  // Configuration writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= `TPRC_MASK_RST;
      recal_r <= `TPRC_RECAL_RST;
      pcfg_r <= `TPRC_PCFG_RST;
    end else if (wr) begin
      if (idx == `TPRC_IDX_MASK)
        mask_r <= wb_dat_i[7:0];
      if (idx == `TPRC_IDX_RECAL)
        recal_r <= wb_dat_i[7:0];
      if (idx == `TPRC_IDX_PCFG)
        pcfg_r <= wb_dat_i[7:0];
    end
  end

  // Thresholds: input one write fans out while broadcast is set
  // Inputs two to eight stay individually writable either way
  generate
    for (g = 0; g < NIN; g = g + 1) begin : g_thr
      always @(posedge clk_i) begin
        if (rst_i) begin
          thr_r[g] <= `TPRC_THR_RST;
        end else if (wr && (idx == `TPRC_IDX_THR1 + g ||
            (recal_r[`TPRC_RC_BCAST] && idx == `TPRC_IDX_THR1))) begin
          thr_r[g] <= wb_dat_i[6:0];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Pattern status and blocking
  // --------------------------------------------------------------------
  // A zero in bit 0 asks for the clear; a standing condition still wins
  wire clr_stat = wr && idx == `TPRC_IDX_STAT && !wb_dat_i[`TPRC_ST_PAT];
  always @(posedge clk_i) begin
    if (rst_i) begin
      cond_r <= 1'b0;
      pattern_event_status_o <= 1'b0;
      touch_block_o <= 1'b0;
      alert_o <= 1'b0;
      bclim_r <= `TPRC_BCLIM_RST;
      base_limit_summary_o <= 1'b0;
    end else begin
      bclim_r <= base_limit_i;
      base_limit_summary_o <= |base_limit_i;
      if (!pcfg_r[`TPRC_PC_EN])
        cond_r <= 1'b0;
      else if (cycle_done_i)
        cond_r <= match;
      touch_block_o <= cond_r;
      // Set wins; clear only once the condition has gone
      if (cond_r)
        pattern_event_status_o <= 1'b1;
      else if (clr_stat)
        pattern_event_status_o <= 1'b0;
      alert_o <= (cond_r & pcfg_r[`TPRC_PC_ALERT]) | (alert_o & ~clr_stat);
    end
  end

  // --------------------------------------------------------------------
  // Negative delta recalibration, shared counter across inputs
  // --------------------------------------------------------------------
  reg [5:0] neg_lim;
  always @* begin
    case (recal_r[`TPRC_RC_NEG_HI:`TPRC_RC_NEG_LO])
      2'b00: neg_lim = `TPRC_NEG_CNT0;
      2'b01: neg_lim = `TPRC_NEG_CNT1;
      2'b10: neg_lim = `TPRC_NEG_CNT2;
      default: neg_lim = 6'd0;
    endcase
  end

  // Noise on any input counts, so one counter serves all inputs
  wire any_noise = |noise_i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      neg_cnt_r <= 6'd0;
      neg_recal_o <= 1'b0;
    end else begin
      neg_recal_o <= 1'b0;
      if (any_noise && !recal_r[`TPRC_RC_KEEPN])
        neg_cnt_r <= 6'd0;
      else if (cycle_done_i) begin
        if (!(|neg_delta_i))
          neg_cnt_r <= 6'd0;
        else if (neg_lim != 6'd0 && neg_cnt_r + 6'd1 >= neg_lim) begin
          neg_cnt_r <= 6'd0;
          neg_recal_o <= 1'b1;
        end else
          neg_cnt_r <= neg_cnt_r + 6'd1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Automatic recalibration: averaging and update period
  // --------------------------------------------------------------------
  wire [2:0] cal = recal_r[`TPRC_RC_CAL_HI:0];
  wire [3:0] sh = cal[2] ? 4'd8 : {2'b00, cal[1:0]} + 4'd4;
  wire [8:0] samp_lim = 9'd1 << sh;
  // Long periods double from 1024 up; code 100 keeps 256
  wire [12:0] per_lim = cal[2] ? (cal[1:0] == 2'b00 ? 13'd256 : 13'd512 << cal[1:0]) :
    13'd16 << cal[1:0];
  reg [DW-1:0] avg_r;
  // Sum with the closing sample; after the shift only DW bits can be set
  wire [DW+8:0] acc_sum = acc_r + {9'd0, sample_i};
  wire [DW+8:0] acc_avg = acc_sum >> sh;

  // One accumulator serves every input; settings are global
  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= {(DW+9){1'b0}};
      samp_cnt_r <= 9'd0;
      per_cnt_r <= 13'd0;
      avg_r <= {DW{1'b0}};
      base_avg_o <= {DW{1'b0}};
      base_update_o <= 1'b0;
    end else begin
      base_update_o <= 1'b0;
      if (any_noise && !recal_r[`TPRC_RC_KEEPI]) begin
        acc_r <= {(DW+9){1'b0}};
        samp_cnt_r <= 9'd0;
      end else if (sample_strobe_i) begin
        if (samp_cnt_r + 9'd1 >= samp_lim) begin
          avg_r <= acc_avg[DW-1:0];
          acc_r <= {(DW+9){1'b0}};
          samp_cnt_r <= 9'd0;
        end else begin
          acc_r <= acc_sum;
          samp_cnt_r <= samp_cnt_r + 9'd1;
        end
      end
      if (cycle_done_i) begin
        if (per_cnt_r + 13'd1 >= per_lim) begin
          per_cnt_r <= 13'd0;
          base_avg_o <= avg_r;
          base_update_o <= 1'b1;
        end else
          per_cnt_r <= per_cnt_r + 13'd1;
      end
    end
  end

endmodule // tprc_core

// >>> hdl/tprc_regs.vh
/*
 * Register map, field positions, reset values and decode constants
 * for the touch pattern and recalibration configuration block.
 * Assumes a 32-bit classic Wishbone slave with byte addresses = 4 x index.
 */
`ifndef TPRC_REGS_VH
`define TPRC_REGS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TPRC_IDX_MASK 8'h2D
`define TPRC_IDX_BCLIM 8'h2E
`define TPRC_IDX_RECAL 8'h2F
`define TPRC_IDX_PCFG 8'h2B
`define TPRC_IDX_STAT 8'h02
`define TPRC_IDX_THR1 8'h30
`define TPRC_IDX_THR8 8'h37

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TPRC_MASK_RST 8'hFF
`define TPRC_BCLIM_RST 8'h00
`define TPRC_RECAL_RST 8'h8A
`define TPRC_PCFG_RST 8'h00
`define TPRC_THR_RST 7'h40

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TPRC_RC_BCAST 7
`define TPRC_RC_KEEPI 6
`define TPRC_RC_KEEPN 5
`define TPRC_RC_NEG_HI 4
`define TPRC_RC_NEG_LO 3
`define TPRC_RC_CAL_HI 2
`define TPRC_PC_EN 7
`define TPRC_PC_TH_HI 3
`define TPRC_PC_TH_LO 2
`define TPRC_PC_CMP 1
`define TPRC_PC_ALERT 0
`define TPRC_ST_BCOUT 1
`define TPRC_ST_PAT 0

// ----------------------------------------------------------------------
// Negative delta trigger counts
// ----------------------------------------------------------------------
`define TPRC_NEG_CNT0 6'd8
`define TPRC_NEG_CNT1 6'd16
`define TPRC_NEG_CNT2 6'd32

`endif

// >>> tb/tb.sv
/* Register-level bench for tprc_core: bus tasks and table-driven tests.
   Assumes tprc_host as bus master and the checker bound to the core. */
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cdone = 1'b0;
  logic [63:0] delta = 64'h0;
  logic [7:0] noise = 8'h00, blim = 8'h00, neg = 8'h00, samp = 8'h37, q;
  logic [47:0] e;
  wire cyc, stb, we, ack, pst, tblk, alrt, bsum, nrec, bupd;
  wire [9:0] adr;
  wire [3:0] sel;
  wire [31:0] wd, rdat;
  wire [7:0] bavg;
  int miscompares = 0, n_tests = 0, nrec_n = 0, bupd_n = 0, b0, per;
  // Rows: config, mask, qualifying, noise, delta, expected event
  logic [47:0] tbl [11] = '{48'h8E8181004101, 48'h8E8180014101, 48'h8E8183004100,
    48'h8E0101004000, 48'h0E8181004100, 48'h8D0FF0004101, 48'h8D0F70004100,
    48'h810180000901, 48'h800101000800, 48'h840101001101, 48'h880101001800};
  int nn [4] = '{8, 16, 32, 40};
  tprc_host u_host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wd));
  tprc_core i_tprc_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cycle_done_i(cdone), .delta_i(delta), .noise_i(noise),
    .base_limit_i(blim), .neg_delta_i(neg), .sample_strobe_i(cdone), .sample_i(samp),
    .pattern_event_status_o(pst), .touch_block_o(tblk), .alert_o(alrt),
    .base_limit_summary_o(bsum), .neg_recal_o(nrec), .base_update_o(bupd),
    .base_avg_o(bavg));
  // ------------------------------------------------------------
  // Clock, pulse counters, tasks
  // ------------------------------------------------------------
  initial forever #25 clk_i = ~clk_i;
  // Count one-cycle pulses, since their latency is left open
  always @(posedge clk_i) begin
    if (nrec === 1'b1) nrec_n++;
    if (bupd === 1'b1) bupd_n++;
  end
  task automatic chk(string nm, logic [7:0] ex, logic [7:0] got);
    n_tests++;
    if (got !== ex) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic rd(logic [7:0] ix, logic [7:0] ex);
    u_host.bus(1'b0, ix, 8'h00, q);
    chk($sformatf("reg %h", ix), ex, q);
  endtask
  task automatic wr(logic [7:0] ix, logic [7:0] d);
    u_host.bus(1'b1, ix, d, q);
  endtask
  // Sensing cycles; samples ride on the same strobe
  task automatic pulses(int n);
    repeat (n) begin
      @(posedge clk_i) cdone <= 1'b1;
      @(posedge clk_i) cdone <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog sized well above the longest recal period sweep
  initial begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h2D, 8'hFF);
    rd(8'h2E, 8'h00);
    rd(8'h2F, 8'h8A);
    rd(8'h2B, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h2D, 8'hA5);
    rd(8'h2D, 8'hA5);
    blim <= 8'h81;
    wr(8'h2E, 8'hFF);
    rd(8'h2E, 8'h81);
    chk("summary", 8'h01, {7'h0, bsum});
    rd(8'h02, 8'h02);
    blim <= 8'h00;
    // Rising periods only, so an old count never overshoots a new one
    for (int c = 0; c < 8; c++) begin
      per = c < 5 ? 16 << c : 1024 << (c - 5);
      wr(8'h2F, {5'b00001, c[2:0]});
      pulses(per);
      b0 = bupd_n;
      pulses(2 * per);
      chk("updates", 8'h02, 8'(bupd_n - b0));
      chk("average", 8'h37, bavg);
    end
    foreach (tbl[i]) begin
      e = tbl[i];
      wr(8'h2B, e[47:40]);
      wr(8'h2D, e[39:32]);
      for (int k = 0; k < 8; k++) delta[k*8+:8] <= e[24+k] ? e[15:8] : 8'h00;
      noise <= e[23:16];
      pulses(1);
      chk("event", e[7:0], {7'h0, pst});
      chk("block", e[7:0], {7'h0, tblk});
      chk("alert", e[7:0] & {7'h0, e[40]}, {7'h0, alrt});
      wr(8'h02, 8'h00);
      @(posedge clk_i);
      chk("held", e[7:0], {7'h0, pst});
      delta <= 64'h0;
      noise <= 8'h00;
      pulses(1);
      wr(8'h02, 8'h00);
      repeat (2) @(posedge clk_i);
      chk("cleared", 8'h00, {7'h0, pst});
    end
    wr(8'h2F, 8'h8A);
    wr(8'h30, 8'h20);
    rd(8'h37, 8'h20);
    wr(8'h37, 8'h11);
    rd(8'h37, 8'h11);
    wr(8'h2F, 8'h0A);
    wr(8'h30, 8'h33);
    rd(8'h31, 8'h20);
    rd(8'h30, 8'h33);
    foreach (nn[c]) begin
      wr(8'h2F, {3'b000, c[1:0], 3'b000});
      neg <= 8'h00;
      pulses(1);
      b0 = nrec_n;
      neg <= 8'h01;
      pulses(nn[c] - 1);
      chk("neg early", 8'h00, 8'(nrec_n - b0));
      pulses(1);
      chk("neg fire", {7'h0, c < 3}, 8'(nrec_n - b0));
    end
    // Both keep bits moved together; noise lands mid-count
    for (int k = 0; k < 2; k++) begin
      wr(8'h2F, k ? 8'h68 : 8'h08);
      neg <= 8'h00;
      pulses(1);
      b0 = nrec_n;
      neg <= 8'h01;
      pulses(8);
      noise <= 8'h01;
      pulses(1);
      noise <= 8'h00;
      pulses(7);
      chk("neg keep", 8'(k), 8'(nrec_n - b0));
      // Accumulator emptied under clearing, then noise lands mid-average
      wr(8'h2F, 8'h08);
      noise <= 8'h01;
      pulses(1);
      noise <= 8'h00;
      wr(8'h2F, k ? 8'h68 : 8'h08);
      samp <= 8'h40;
      pulses(8);
      noise <= 8'h01;
      pulses(1);
      noise <= 8'h00;
      samp <= 8'h00;
      pulses(7);
      // Held noise freezes the average only under clearing (k=0); one period ends either way
      noise <= 8'h01;
      pulses(16);
      noise <= 8'h00;
      chk("avg keep", k ? 8'h24 : 8'h37, bavg);
    end
    complete_run();
  end
endmodule // tb

// >>> tb/tprc_assertions.sv
/* Concurrent checks on tprc_core ports: bus timing, status and pulses.
   Assumes one clock with synchronous active-high reset. */
`timescale 1ns/1ps
`include "tprc_regs.vh"
module tprc_assertions #(
  parameter DW = 8,
  parameter NIN = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [NIN-1:0] base_limit_i,
  input wire pattern_event_status_o,
  input wire touch_block_o,
  input wire alert_o,
  input wire base_limit_summary_o,
  input wire neg_recal_o,
  input wire base_update_o
);
  // Index decode; unmapped reads must come back zero
  wire [7:0] ix = wb_adr_i[9:2];
  wire mapped = ix == `TPRC_IDX_MASK || ix == `TPRC_IDX_BCLIM || ix == `TPRC_IDX_RECAL ||
    ix == `TPRC_IDX_PCFG || ix == `TPRC_IDX_STAT ||
    (ix >= `TPRC_IDX_THR1 && ix <= `TPRC_IDX_THR8);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  ack_one_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  summary_or_a: assert property (!$past(rst_i) |->
    base_limit_summary_o == |$past(base_limit_i))
    else $error("summary not OR of flags");
  alert_status_a: assert property (alert_o |-> pattern_event_status_o)
    else $error("alert without status");
  block_status_a: assert property (touch_block_o |-> pattern_event_status_o)
    else $error("block without status");
  status_clear_a: assert property ($fell(pattern_event_status_o) |->
    $past(wb_cyc_i && wb_stb_i && wb_we_i && ix == `TPRC_IDX_STAT))
    else $error("status cleared without write");
  neg_pulse_a: assert property (neg_recal_o |=> !neg_recal_o)
    else $error("recal trigger not a pulse");
  upd_pulse_a: assert property (base_update_o |=> !base_update_o)
    else $error("base update not a pulse");
  cover property ($rose(pattern_event_status_o));
  cover property (alert_o);
  cover property (neg_recal_o);
  cover property (base_update_o);
endmodule // tprc_assertions
bind tprc_core tprc_assertions #(.DW(DW), .NIN(NIN)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .base_limit_i(base_limit_i),
  .pattern_event_status_o(pattern_event_status_o), .touch_block_o(touch_block_o),
  .alert_o(alert_o), .base_limit_summary_o(base_limit_summary_o),
  .neg_recal_o(neg_recal_o), .base_update_o(base_update_o));

// >>> tb/tprc_host.sv
/* Wishbone classic host model for the tprc_core register port.
   Assumes one caller at a time and a clock shared with the core. */
`timescale 1ns/1ps
module tprc_host (
  input wire clk_i,
  input wire wb_ack_i,
  input wire [31:0] wb_dat_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [9:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  // Bus idle from time zero
  initial begin
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
  end
  // One classic cycle held until ack; the bench watchdog ends a dead wait
  task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= {ix, 2'b00};
    wb_sel_o <= 4'hF;
    wb_dat_o <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_i !== 1'b1);
    q = wb_dat_i[7:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
  endtask
endmodule // tprc_host
